// >>> rtl/pwred_consts.svh
`ifndef PWRED_CONSTS_SVH
`define PWRED_CONSTS_SVH

// Register offsets within the port block (low 12 address bits)
`define PWRED_OFS_POINTER     12'h804
`define PWRED_OFS_POLICE_CTRL 12'h80c
`define PWRED_OFS_QUEUE_RATE  12'h820
`define PWRED_OFS_QUEUE_BURST 12'h824
`define PWRED_OFS_MEM_THRESH  12'h830
`define PWRED_OFS_MEM_SCALE   12'h834

// Policing control bit positions
`define PWRED_BIT_ENABLE      0
`define PWRED_BIT_BLIND       1
`define PWRED_BIT_DROP_SRP    2
`define PWRED_BIT_REMAP       3
`define PWRED_BIT_MARK        4
`define PWRED_BIT_NONIP_LO    5
`define PWRED_BIT_PORT_BASED  7
`define PWRED_BIT_PTYPE_LO    8
`define PWRED_BIT_DROP_ALL    10
`define PWRED_BIT_DROP_COLOR  11
`define PWRED_CTRL_W          12
`define PWRED_CTRL_RESET      12'h020

// Pointer and split-word field positions
`define PWRED_PORT_IDX_LO     16
`define PWRED_QUEUE_PTR_LO    0
`define PWRED_HI_LO           16

// Reset values
`define PWRED_CRATE_RESET     16'h1000
`define PWRED_PRATE_RESET     16'h2000
`define PWRED_CBS_RESET       16'h1000
`define PWRED_PBS_RESET       16'h3000
`define PWRED_MAX_RESET       11'h400
`define PWRED_MIN_RESET       11'h080
`define PWRED_SCALE_RESET     11'h020

// Random generator seed, any nonzero value
`define PWRED_RAND_SEED       22'h15a5a5

`endif

// >>> rtl/pwred_pkg.sv
package pwred_pkg;

    // Monitor selection codes, also used as frame colour codes
    typedef enum logic [1:0] {
        PWRED_MON_DROPPED = 2'b00,
        PWRED_MON_GREEN   = 2'b01,
        PWRED_MON_YELLOW  = 2'b10,
        PWRED_MON_RED     = 2'b11
    } pwred_mon_t;

    typedef logic [10:0] pwred_level_t;

endpackage

// >>> rtl/pwred_if.sv
interface pwred_if;
    logic                  req;
    logic                  drop_all;
    pwred_pkg::pwred_level_t avg;
    pwred_pkg::pwred_level_t min_level;
    pwred_pkg::pwred_level_t max_level;
    pwred_pkg::pwred_level_t scale;
    logic                  done;
    logic                  drop;

    modport requester (output req, drop_all, avg, min_level, max_level, scale,
                       input done, drop);
    modport decider   (input req, drop_all, avg, min_level, max_level, scale,
                       output done, drop);
endinterface

// >>> rtl/pwred_drop.sv
`include "pwred_consts.svh"

module pwred_drop (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Decision request and answer
    pwred_if.decider  dec
);

    logic [21:0] rand_q;
    logic [10:0] excess;
    logic [21:0] prob;
    logic        below;
    logic        above;
    logic        drop_d;

    // Pseudo-random source, maximal length for 22 bits
    always_ff @(posedge clock) begin
        if (reset) begin
            rand_q <= `PWRED_RAND_SEED;
        end else begin
            rand_q <= {rand_q[20:0], rand_q[21] ^ rand_q[20]};
        end
    end

    // Drop probability grows with occupancy above the minimum
    assign below  = dec.avg < dec.min_level;
    assign above  = dec.avg > dec.max_level;
    assign excess = dec.avg - dec.min_level;
    assign prob   = {11'h000, excess} * {11'h000, dec.scale};

    assign drop_d = !below && ((above && dec.drop_all) || (rand_q < prob));

    // Answer one cycle after the request
    always_ff @(posedge clock) begin
        if (reset) begin
            dec.done <= 1'b0;
            dec.drop <= 1'b0;
        end else begin
            dec.done <= dec.req;
            dec.drop <= dec.req & drop_d;
        end
    end

endmodule

// >>> rtl/pwred_top.sv
`include "pwred_consts.svh"

module pwred_top #(
    parameter logic [3:0] PORT_NUM = 4'h1,
    parameter int          CNT_W    = 24
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // Management register access
    input  wire logic [15:0]        reg_addr,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [31:0]        reg_wdata,
    output logic      [31:0]        reg_rdata_q,
    output logic                    reg_ack_q,
    // Packet memory occupancy
    input  wire logic [10:0]        avg_occupancy,
    // Ingress frame request
    input  wire logic               pkt_valid,
    input  wire logic [1:0]         pkt_queue,
    input  wire logic               pkt_is_ip,
    input  wire logic               pkt_is_srp,
    input  wire logic [1:0]         pkt_dscp_color,
    input  wire logic [1:0]         pkt_remap_color,
    // Ingress frame verdict
    output logic                    pkt_done_q,
    output logic                    pkt_drop_q,
    output logic [1:0]              pkt_color_q,
    output logic                    pkt_mark_q,
    // Meter parameter lookup
    input  wire logic [2:0]         meter_port,
    input  wire logic [1:0]         meter_queue,
    output logic [15:0]             committed_rate_q,
    output logic [15:0]             peak_rate_q,
    output logic [15:0]             committed_burst_q,
    output logic [15:0]             peak_burst_q,
    // Configuration state and queue event monitor
    output logic                    police_enable_q,
    output logic                    color_blind_q,
    output logic [CNT_W-1:0]        queue_event_monitor_q
);

    logic [2:0]                   port_idx_q;
    logic [1:0]                   queue_ptr_q;
    logic [`PWRED_CTRL_W-1:0]     ctrl_q;
    logic [31:0]                  rate_mem  [0:31];
    logic [31:0]                  burst_mem [0:31];
    pwred_pkg::pwred_level_t      mem_max_q;
    pwred_pkg::pwred_level_t      mem_min_q;
    pwred_pkg::pwred_level_t      scale_q;
    logic [CNT_W-1:0]             cnt_q [0:3][0:3];
    logic [31:0]                  rdata_d;
    logic [4:0]                   sel_idx;
    logic [4:0]                   meter_idx;
    logic [1:0]                   color_d;
    logic [1:0]                   s1_color_q;
    logic [1:0]                   s1_queue_q;
    logic                         s1_srp_q;
    logic                         s1_ip_q;
    logic                         drop_now;
    pwred_pkg::pwred_mon_t        mon_sel;

    pwred_if wred ();

    // Full 16-bit address match against this port's block
    function automatic logic hit(input logic [15:0] addr, input logic [11:0] ofs);
        hit = (addr == {PORT_NUM, ofs});
    endfunction

    // Table index from port and queue
    function automatic logic [4:0] tbl_idx(input logic [2:0] port, input logic [1:0] queue);
        tbl_idx = {port, queue};
    endfunction

    assign sel_idx = tbl_idx(port_idx_q, queue_ptr_q);
    // aggregated metering uses port zero entries
    assign meter_idx = ctrl_q[`PWRED_BIT_PORT_BASED] ? tbl_idx(meter_port, meter_queue)
                                                     : tbl_idx(3'h0, meter_queue);
    assign mon_sel = pwred_pkg::pwred_mon_t'(ctrl_q[`PWRED_BIT_PTYPE_LO +: 2]);

    // Pointer register
    always_ff @(posedge clock) begin
        if (reset) begin
            port_idx_q  <= 3'h0;
            queue_ptr_q <= 2'h0;
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_POINTER)) begin
            port_idx_q  <= reg_wdata[`PWRED_PORT_IDX_LO +: 3];
            queue_ptr_q <= reg_wdata[`PWRED_QUEUE_PTR_LO +: 2];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= `PWRED_CTRL_RESET;
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_POLICE_CTRL)) begin
            ctrl_q <= reg_wdata[`PWRED_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                rate_mem[i]  <= {`PWRED_CRATE_RESET, `PWRED_PRATE_RESET};
                burst_mem[i] <= {`PWRED_CBS_RESET, `PWRED_PBS_RESET};
            end
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_QUEUE_RATE)) begin
            rate_mem[sel_idx] <= reg_wdata;
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_QUEUE_BURST)) begin
            burst_mem[sel_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mem_max_q <= `PWRED_MAX_RESET;
            mem_min_q <= `PWRED_MIN_RESET;
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_MEM_THRESH)) begin
            mem_max_q <= reg_wdata[`PWRED_HI_LO +: 11];
            mem_min_q <= reg_wdata[10:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            scale_q <= `PWRED_SCALE_RESET;
        end else if (reg_wr && hit(reg_addr, `PWRED_OFS_MEM_SCALE)) begin
            scale_q <= reg_wdata[`PWRED_HI_LO +: 11];
        end
    end

    // Read data mux
    // reserved bits read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(reg_addr, `PWRED_OFS_POINTER)) begin
            rdata_d[`PWRED_PORT_IDX_LO +: 3]  = port_idx_q;
            rdata_d[`PWRED_QUEUE_PTR_LO +: 2] = queue_ptr_q;
        end else if (hit(reg_addr, `PWRED_OFS_POLICE_CTRL)) begin
            rdata_d[`PWRED_CTRL_W-1:0] = ctrl_q;
        end else if (hit(reg_addr, `PWRED_OFS_QUEUE_RATE)) begin
            rdata_d = rate_mem[sel_idx];
        end else if (hit(reg_addr, `PWRED_OFS_QUEUE_BURST)) begin
            rdata_d = burst_mem[sel_idx];
        end else if (hit(reg_addr, `PWRED_OFS_MEM_THRESH)) begin
            rdata_d[`PWRED_HI_LO +: 11] = mem_max_q;
            rdata_d[10:0]               = mem_min_q;
        end else if (hit(reg_addr, `PWRED_OFS_MEM_SCALE)) begin
            rdata_d[`PWRED_HI_LO +: 11] = scale_q;
            rdata_d[10:0]               = avg_occupancy;
        end
    end

    // Register answer, one cycle after the access
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata_q <= 32'h0000_0000;
            reg_ack_q   <= 1'b0;
        end else begin
            reg_ack_q <= reg_rd | reg_wr;
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

    // Ingress colour ahead of the meter
    always_comb begin
        color_d = pkt_dscp_color;
        if (ctrl_q[`PWRED_BIT_BLIND]) begin
            color_d = pwred_pkg::PWRED_MON_GREEN;
        end else if (!pkt_is_ip) begin
            color_d = ctrl_q[`PWRED_BIT_NONIP_LO +: 2];
        end else if (ctrl_q[`PWRED_BIT_REMAP]) begin
            color_d = pkt_remap_color;
        end
    end

    // Decision request to the drop unit
    assign wred.req       = pkt_valid;
    assign wred.drop_all  = ctrl_q[`PWRED_BIT_DROP_ALL];
    assign wred.avg       = avg_occupancy;
    assign wred.min_level = mem_min_q;
    assign wred.max_level = mem_max_q;
    assign wred.scale     = scale_q;

    pwred_drop u_drop (
        .clock (clock),
        .reset (reset),
        .dec   (wred.decider)
    );

    // Frame details held while the decision is made
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_color_q <= 2'h0;
            s1_queue_q <= 2'h0;
            s1_srp_q   <= 1'b0;
            s1_ip_q    <= 1'b0;
        end else if (pkt_valid) begin
            s1_color_q <= color_d;
            s1_queue_q <= pkt_queue;
            s1_srp_q   <= pkt_is_srp;
            s1_ip_q    <= pkt_is_ip;
        end
    end

    assign drop_now = wred.drop && ctrl_q[`PWRED_BIT_ENABLE] &&
                      (!s1_srp_q || ctrl_q[`PWRED_BIT_DROP_SRP]);

    // Verdict outputs
    always_ff @(posedge clock) begin
        if (reset) begin
            pkt_done_q  <= 1'b0;
            pkt_drop_q  <= 1'b0;
            pkt_color_q <= 2'h0;
            pkt_mark_q  <= 1'b0;
        end else begin
            pkt_done_q  <= wred.done;
            pkt_drop_q  <= wred.done & drop_now;
            pkt_color_q <= s1_color_q;
            pkt_mark_q  <= wred.done & s1_ip_q & ctrl_q[`PWRED_BIT_ENABLE] &
                           ctrl_q[`PWRED_BIT_MARK];
        end
    end

    // event counters, colour count gated by dropped-only mode
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int q = 0; q < 4; q++) begin
                for (int t = 0; t < 4; t++) begin
                    cnt_q[q][t] <= '0;
                end
            end
        end else if (wred.done) begin
            if (drop_now) begin
                cnt_q[s1_queue_q][pwred_pkg::PWRED_MON_DROPPED] <=
                    cnt_q[s1_queue_q][pwred_pkg::PWRED_MON_DROPPED] + 1'b1;
            end
            if (s1_color_q != pwred_pkg::PWRED_MON_DROPPED &&
                (drop_now || !ctrl_q[`PWRED_BIT_DROP_COLOR])) begin
                cnt_q[s1_queue_q][s1_color_q] <= cnt_q[s1_queue_q][s1_color_q] + 1'b1;
            end
        end
    end

    // monitor output for the pointed queue
    always_ff @(posedge clock) begin
        if (reset) begin
            queue_event_monitor_q <= '0;
        end else begin
            queue_event_monitor_q <= cnt_q[queue_ptr_q][mon_sel];
        end
    end

    // Meter parameters and configuration state
    always_ff @(posedge clock) begin
        if (reset) begin
            committed_rate_q  <= `PWRED_CRATE_RESET;
            peak_rate_q       <= `PWRED_PRATE_RESET;
            committed_burst_q <= `PWRED_CBS_RESET;
            peak_burst_q      <= `PWRED_PBS_RESET;
            police_enable_q   <= 1'b0;
            color_blind_q     <= 1'b0;
        end else begin
            committed_rate_q  <= rate_mem[meter_idx][`PWRED_HI_LO +: 16];
            peak_rate_q       <= rate_mem[meter_idx][15:0];
            committed_burst_q <= burst_mem[meter_idx][`PWRED_HI_LO +: 16];
            peak_burst_q      <= burst_mem[meter_idx][15:0];
            police_enable_q   <= ctrl_q[`PWRED_BIT_ENABLE];
            color_blind_q     <= ctrl_q[`PWRED_BIT_BLIND];
        end
    end

endmodule

// >>> tb/pwred_properties.sv
module pwred_properties #(
    parameter logic [3:0] PORT_NUM = 4'h1
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // Register access
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        reg_ack_q,
    // Frame path
    input wire logic        pkt_valid,
    input wire logic        pkt_done_q,
    input wire logic        pkt_drop_q,
    input wire logic [1:0]  pkt_color_q,
    // Meter lookup and state
    input wire logic [2:0]  meter_port,
    input wire logic [1:0]  meter_queue,
    input wire logic [15:0] committed_rate_q,
    input wire logic [15:0] peak_rate_q,
    input wire logic        police_enable_q,
    input wire logic        color_blind_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_ack_follows: assert property (
        (reg_rd || reg_wr) |=> reg_ack_q) else $error("ack missing after request");
    a_enable_mirror: assert property (
        reg_wr && reg_addr == {PORT_NUM, 12'h80c} |=> ##1
        police_enable_q == $past(reg_wdata[0], 2)) else $error("enable not taken");
    a_blind_mirror: assert property (
        reg_wr && reg_addr == {PORT_NUM, 12'h80c} |=> ##1
        color_blind_q == $past(reg_wdata[1], 2)) else $error("blind mode not taken");
    a_ctrl_reserved: assert property (
        reg_ack_q && $past(reg_rd) && $past(reg_addr) == {PORT_NUM, 12'h80c}
        |-> reg_rdata_q[31:12] == 20'h0) else $error("control reserved bits set");
    a_thresh_reserved: assert property (
        reg_ack_q && $past(reg_rd) && $past(reg_addr) == {PORT_NUM, 12'h830}
        |-> reg_rdata_q[31:27] == 5'h0 && reg_rdata_q[15:11] == 5'h0)
        else $error("threshold reserved bits set");
    a_no_drop_off: assert property (
        pkt_done_q && !police_enable_q && !$past(police_enable_q)
        && !$past(police_enable_q, 2) |-> !pkt_drop_q) else $error("drop while disabled");
    a_blind_green: assert property (
        pkt_done_q && color_blind_q && $past(color_blind_q) && police_enable_q
        && $past(police_enable_q, 2) |-> pkt_color_q == 2'b01) else $error("blind not green");
    a_verdict_latency: assert property (
        pkt_valid |-> ##2 pkt_done_q) else $error("verdict late");
    a_color_holds: assert property (
        !pkt_done_q |-> $stable(pkt_color_q)) else $error("colour changed without verdict");
    a_meter_stable: assert property (
        !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) && $stable(meter_port)
        && $stable(meter_queue) |=> $stable(committed_rate_q) && $stable(peak_rate_q))
        else $error("meter output changed");
endmodule

bind pwred_top pwred_properties #(.PORT_NUM(PORT_NUM)) pwred_properties_inst (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_ack_q(reg_ack_q), .pkt_valid(pkt_valid), .pkt_done_q(pkt_done_q),
    .pkt_drop_q(pkt_drop_q), .pkt_color_q(pkt_color_q), .meter_port(meter_port),
    .meter_queue(meter_queue), .committed_rate_q(committed_rate_q),
    .peak_rate_q(peak_rate_q), .police_enable_q(police_enable_q),
    .color_blind_q(color_blind_q)
);

// >>> tb/test_pwred_top.sv
module test_pwred_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] PORT_NUM = 4'h1;
    logic        clock, reset, reg_wr, reg_rd, pkt_valid, pkt_is_ip, pkt_is_srp;
    logic        reg_ack_q, pkt_done_q, pkt_drop_q, pkt_mark_q;
    logic        police_enable_q, color_blind_q;
    logic [15:0] reg_addr, committed_rate_q, peak_rate_q, committed_burst_q, peak_burst_q;
    logic [31:0] reg_wdata, reg_rdata_q;
    logic [10:0] avg_occupancy;
    logic [1:0]  pkt_queue, pkt_dscp_color, pkt_remap_color, pkt_color_q, meter_queue;
    logic [2:0]  meter_port;
    logic [23:0] queue_event_monitor_q;
    int          n_errors = 0;
    int          num_checks = 0;

    pwred_top #(.PORT_NUM(PORT_NUM), .CNT_W(24)) pwred_top_inst (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_ack_q(reg_ack_q), .avg_occupancy(avg_occupancy), .pkt_valid(pkt_valid),
        .pkt_queue(pkt_queue), .pkt_is_ip(pkt_is_ip), .pkt_is_srp(pkt_is_srp),
        .pkt_dscp_color(pkt_dscp_color), .pkt_remap_color(pkt_remap_color),
        .pkt_done_q(pkt_done_q), .pkt_drop_q(pkt_drop_q), .pkt_color_q(pkt_color_q),
        .pkt_mark_q(pkt_mark_q), .meter_port(meter_port), .meter_queue(meter_queue),
        .committed_rate_q(committed_rate_q), .peak_rate_q(peak_rate_q),
        .committed_burst_q(committed_burst_q), .peak_burst_q(peak_burst_q),
        .police_enable_q(police_enable_q), .color_blind_q(color_blind_q),
        .queue_event_monitor_q(queue_event_monitor_q)
    );

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Compare one value
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        @(negedge clock);
        reg_addr = {PORT_NUM, ofs};
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        chk_reg({31'h0, reg_ack_q}, 32'h1);
    endtask

    // Read, then compare the word delivered with the ack
    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp);
        @(negedge clock);
        reg_addr = {PORT_NUM, ofs};
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk_reg({31'h0, reg_ack_q}, 32'h1);
        chk_reg(reg_rdata_q, exp);
    endtask

    // One frame; returns at the verdict cycle
    task automatic send(input logic ip, srp, input logic [1:0] dscp, remap);
        @(negedge clock);
        pkt_is_ip = ip;
        pkt_is_srp = srp;
        pkt_dscp_color = dscp;
        pkt_remap_color = remap;
        pkt_valid = 1'b1;
        @(negedge clock);
        pkt_valid = 1'b0;
        @(negedge clock);
    endtask

    // Control setting, occupancy, one frame and its masked verdict
    task automatic frame(input logic [11:0] ctrl, input logic ip, srp,
                         input logic [1:0] dscp, remap, input logic [10:0] avg,
                         input logic [4:0] mask, exp);
        wr(12'h80c, {20'h0, ctrl});
        avg_occupancy = avg;
        send(ip, srp, dscp, remap);
        chk_reg({27'h0, {pkt_done_q, pkt_drop_q, pkt_mark_q, pkt_color_q} & mask},
                {27'h0, exp});
    endtask

    // Monitor growth over one droppable and one protected frame
    task automatic mon(input logic [11:0] ctrl, input logic [23:0] delta);
        logic [23:0] base;
        wr(12'h80c, {20'h0, ctrl});
        avg_occupancy = 11'h200;
        repeat (2) @(posedge clock);
        #1;
        base = queue_event_monitor_q;
        send(1'b0, 1'b0, 2'b01, 2'b01);
        send(1'b0, 1'b1, 2'b01, 2'b01);
        repeat (2) @(posedge clock);
        #1;
        chk_reg({8'h0, queue_event_monitor_q - base}, {8'h0, delta});
    endtask

    // Meter table lookup
    task automatic meter_chk(input logic [2:0] p, input logic [1:0] q,
                             input logic [31:0] rate, burst);
        @(negedge clock);
        meter_port = p;
        meter_queue = q;
        repeat (2) @(negedge clock);
        chk_reg({committed_rate_q, peak_rate_q}, rate);
        chk_reg({committed_burst_q, peak_burst_q}, burst);
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        {reset, reg_wr, reg_rd, pkt_valid, pkt_is_ip, pkt_is_srp} = 6'h20;
        {reg_addr, reg_wdata} = 48'h0;
        {pkt_queue, pkt_dscp_color, pkt_remap_color, meter_port, meter_queue} = 11'h0;
        avg_occupancy = 11'h155;
        repeat (6) @(negedge clock);
        reset = 1'b0;
        rd_chk(12'h804, 32'h00000000);
        rd_chk(12'h80c, 32'h00000020);
        rd_chk(12'h820, 32'h10002000);
        rd_chk(12'h824, 32'h10003000);
        rd_chk(12'h830, 32'h04000080);
        rd_chk(12'h834, 32'h00200155);
        wr(12'h80c, 32'hffffffff);
        rd_chk(12'h80c, 32'h00000fff);
        chk_reg({30'h0, police_enable_q, color_blind_q}, 32'h3);
        wr(12'h80c, 32'h0);
        rd_chk(12'h80c, 32'h00000000);
        wr(12'h804, 32'hffffffff);
        rd_chk(12'h804, 32'h00070003);
        wr(12'h830, 32'hffffffff);
        rd_chk(12'h830, 32'h07ff07ff);
        wr(12'h834, 32'hffffffff);
        rd_chk(12'h834, 32'h07ff0155);
        wr(12'h810, 32'hffffffff);
        rd_chk(12'h810, 32'h00000000);
        wr(12'h804, 32'h00030002);
        wr(12'h820, 32'habcd1234);
        wr(12'h824, 32'h5555aaaa);
        wr(12'h804, 32'h00030001);
        rd_chk(12'h820, 32'h10002000);
        wr(12'h804, 32'h00020002);
        rd_chk(12'h824, 32'h10003000);
        wr(12'h804, 32'h00030002);
        rd_chk(12'h820, 32'habcd1234);
        rd_chk(12'h824, 32'h5555aaaa);
        wr(12'h80c, 32'h00000080);
        meter_chk(3'h3, 2'h2, 32'habcd1234, 32'h5555aaaa);
        wr(12'h804, 32'h00000002);
        wr(12'h820, 32'h00110022);
        wr(12'h80c, 32'h0);
        meter_chk(3'h3, 2'h2, 32'h00110022, 32'h10003000);
        wr(12'h830, 32'h01000080);
        frame(12'h000, 1'b0, 1'b0, 2'h1, 2'h1, 11'h200, 5'h1c, 5'h10);
        frame(12'h403, 1'b1, 1'b0, 2'h2, 2'h3, 11'h200, 5'h1f, 5'h19);
        frame(12'h461, 1'b0, 1'b0, 2'h1, 2'h1, 11'h010, 5'h1f, 5'h13);
        frame(12'h001, 1'b1, 1'b0, 2'h2, 2'h3, 11'h010, 5'h1f, 5'h12);
        frame(12'h009, 1'b1, 1'b0, 2'h2, 2'h3, 11'h010, 5'h1f, 5'h13);
        frame(12'h011, 1'b1, 1'b0, 2'h1, 2'h2, 11'h010, 5'h1f, 5'h15);
        frame(12'h401, 1'b1, 1'b1, 2'h1, 2'h1, 11'h200, 5'h1f, 5'h11);
        frame(12'h405, 1'b1, 1'b1, 2'h1, 2'h1, 11'h200, 5'h1f, 5'h19);
        wr(12'h834, 32'h0);
        frame(12'h001, 1'b1, 1'b0, 2'h1, 2'h1, 11'h200, 5'h1f, 5'h11);
        wr(12'h804, 32'h0);
        mon(12'h401, 24'h1);
        mon(12'h503, 24'h2);
        mon(12'hd03, 24'h1);
        mon(12'h641, 24'h2);
        mon(12'h761, 24'h2);
        stop_test();
    end
endmodule
